/* verilog/gpc_pin_pair.sv */
// Control register and read-back for general-purpose I/O pins 0 and 1.
// Assumes a single-cycle register port and pin inputs synchronous to mclk.

`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Bit 0 turns pin 0 input mode on.
// - Pin 0 level latched after reset as strap.
// - Bit 1 enables pin 0 output, reset off.
// - Bit 2 picks data or test source.
// - Bit 3 drives pin 0, reads pin level when bit 0 is set.
// - Bit 4 pin 1 input mode and strap.
// - Bit 5 enables pin 1 output, reset off.
// - Bit 6 picks pin 1 data or test.
// - Bit 7 is driven onto pin 1.
// - Reading bit 7 returns pin 1 level when bit 4 is set, else the stored bit.
module gpc_pin_pair
   import gpc_pkg::*;
#(
   parameter int          NPIN     = GPC_NUM_PINS,
   parameter logic [7:0]  CTRL_RST = GPC_CTRL_RST
) (
   input  wire logic                  mclk,
   input  wire logic                  srst,
   input  wire logic                  ce,
   input  wire logic [GPC_ADDR_W-1:0] addr,
   input  wire logic [GPC_DATA_W-1:0] wr_data,
   input  wire logic                  wr_stb,
   input  wire logic                  rd_stb,
   output var  logic [GPC_DATA_W-1:0] rd_data,
   input  wire logic [NPIN-1:0]       gpio_i,
   output var  logic [NPIN-1:0]       gpio_o,
   output var  logic [NPIN-1:0]       gpio_oe,
   input  wire logic [NPIN-1:0]       test_sig,
   output var  logic [NPIN-1:0]       mode_strap,
   output var  logic                  mode_strap_valid
);

   // =========================================================================
   // Field access
   // =========================================================================
   function automatic logic fld(input logic [GPC_CTRL_W-1:0] c, input int pin, input int f);
      fld = c[pin * GPC_PIN_STRIDE + f];
   endfunction

   // =========================================================================
   // Control register
   // =========================================================================
   logic [GPC_CTRL_W-1:0] ctrl_r;
   wire logic             hit_ctrl;
   wire logic             hit_strap;

   assign hit_ctrl  = (addr == GPC_OFS_PIN_CTRL);
   assign hit_strap = (addr == GPC_OFS_STRAP);

   // The data bits store what software writes even while input mode is on,
   // so turning the output on later drives the last value written.
   always_ff @(posedge mclk) begin
      if (srst) begin
         ctrl_r <= CTRL_RST;
      end else if (ce && wr_stb && hit_ctrl) begin
         ctrl_r <= wr_data[GPC_CTRL_W-1:0];
      end
   end

   // =========================================================================
   // Per-pin decode and output cells
   // =========================================================================
   logic [NPIN-1:0]       in_en;
   logic [NPIN-1:0]       rd_bit;
   logic [GPC_CTRL_W-1:0] ctrl_view;

   generate
      for (genvar p = 0; p < NPIN; p++) begin : g_pin
         assign in_en[p]  = fld(ctrl_r, p, GPC_FLD_IN_EN);
         // Input mode shows the pin; otherwise the stored data bit reads back.
         assign rd_bit[p] = in_en[p] ? gpio_i[p] : fld(ctrl_r, p, GPC_FLD_DATA);

         gpc_pin_cell u_cell (
            .mclk     (mclk),
            .srst     (srst),
            .ce       (ce),
            .out_en   (fld(ctrl_r, p, GPC_FLD_OUT_EN)),
            .src_sel  (fld(ctrl_r, p, GPC_FLD_SRC_SEL)),
            .data_bit (fld(ctrl_r, p, GPC_FLD_DATA)),
            .test_sig (test_sig[p]),
            .pin_o    (gpio_o[p]),
            .pin_oe   (gpio_oe[p])
         );
      end
   endgenerate

   always_comb begin
      ctrl_view = ctrl_r;
      for (int p = 0; p < NPIN; p++) begin
         ctrl_view[p * GPC_PIN_STRIDE + GPC_FLD_DATA] = rd_bit[p];
      end
   end

   // =========================================================================
   // Strap capture
   // =========================================================================
   gpc_strap_latch #(
      .N (NPIN)
   ) u_strap (
      .mclk        (mclk),
      .srst        (srst),
      .ce          (ce),
      .pin_in      (gpio_i),
      .in_en       (in_en),
      .strap       (mode_strap),
      .strap_valid (mode_strap_valid)
   );

   // =========================================================================
   // Read port
   // =========================================================================
   // Unmapped addresses read as zero; the data is valid only in the cycle
   // after the strobe and is cleared on other edges with ce high; with ce low it holds.
   logic [GPC_DATA_W-1:0] rd_mux;

   always_comb begin
      rd_mux = GPC_READ_ZERO;
      if (hit_ctrl) begin
         rd_mux[GPC_CTRL_W-1:0] = ctrl_view;
      end else if (hit_strap) begin
         rd_mux[NPIN-1:0]        = mode_strap;
         rd_mux[GPC_STRAP_VALID] = mode_strap_valid;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         rd_data <= GPC_READ_ZERO;
      end else if (ce) begin
         rd_data <= rd_stb ? rd_mux : GPC_READ_ZERO;
      end
   end

endmodule

`default_nettype wire

/* verilog/gpc_pkg.sv */
// Constants for the two-pin general-purpose I/O control block.
// Assumes a 32-bit register port with byte addresses and one clock domain.

package gpc_pkg;

   // =========================================================================
   // Register map
   // =========================================================================
   localparam int          GPC_ADDR_W        = 12;
   localparam int          GPC_DATA_W        = 32;
   localparam logic [11:0] GPC_OFS_PIN_CTRL  = 12'h0008;
   localparam logic [11:0] GPC_OFS_STRAP     = 12'h000C;

   // =========================================================================
   // Per-pin field layout, repeated every GPC_PIN_STRIDE bits
   // =========================================================================
   localparam int          GPC_NUM_PINS      = 2;
   localparam int          GPC_PIN_STRIDE    = 4;
   localparam int          GPC_FLD_IN_EN     = 0;
   localparam int          GPC_FLD_OUT_EN    = 1;
   localparam int          GPC_FLD_SRC_SEL   = 2;
   localparam int          GPC_FLD_DATA      = 3;
   localparam int          GPC_CTRL_W        = 8;

   // Input enabled, output disabled, pin data source, data low, per pin.
   localparam logic [7:0]  GPC_CTRL_RST      = 8'h11;

   // =========================================================================
   // Strap status register layout
   // =========================================================================
   localparam int          GPC_STRAP_VALID   = 2;
   localparam logic [31:0] GPC_READ_ZERO     = 32'h0000_0000;

endpackage

/* verilog/gpc_pin_cell.sv */
// Output path of one I/O pin: source select, data and output enable.
// Assumes the pin wire is resolved outside from pin_o and pin_oe.

`timescale 1ns/1ps
`default_nettype none

module gpc_pin_cell (
   input  wire logic mclk,
   input  wire logic srst,
   input  wire logic ce,
   input  wire logic out_en,
   input  wire logic src_sel,
   input  wire logic data_bit,
   input  wire logic test_sig,
   output var  logic pin_o,
   output var  logic pin_oe
);

   // =========================================================================
   // Driver selection
   // =========================================================================
   wire logic pin_o_nxt;

   // The test source is only meant for factory test mode.
   assign pin_o_nxt = src_sel ? test_sig : data_bit;

   always_ff @(posedge mclk) begin
      if (srst) begin
         pin_o  <= 1'b0;
         pin_oe <= 1'b0;
      end else if (ce) begin
         pin_o  <= pin_o_nxt;
         pin_oe <= out_en;
      end
   end

endmodule

`default_nettype wire

/* verilog/gpc_strap_latch.sv */
// Captures the mode-select straps once, at the first enabled edge after reset.
// Assumes pin levels are synchronous to mclk and held stable around release.

`timescale 1ns/1ps
`default_nettype none

module gpc_strap_latch #(
   parameter int N = 2
) (
   input  wire logic         mclk,
   input  wire logic         srst,
   input  wire logic         ce,
   input  wire logic [N-1:0] pin_in,
   input  wire logic [N-1:0] in_en,
   output var  logic [N-1:0] strap,
   output var  logic         strap_valid
);

   // =========================================================================
   // One-shot capture at the trailing edge of reset
   // =========================================================================
   // A pin whose input mode is off reads back as a zero strap.
   always_ff @(posedge mclk) begin
      if (srst) begin
         strap       <= '0;
         strap_valid <= 1'b0;
      end else if (ce && !strap_valid) begin
         strap       <= pin_in & in_en;
         strap_valid <= 1'b1;
      end
   end

endmodule

`default_nettype wire

/* test/gpc_pin_pair_props.sv */
// Port assertions for the two-pin I/O control block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module gpc_pin_pair_props
   import gpc_pkg::*;
#(
   parameter int NPIN = 2
) (
   input wire logic                  mclk,
   input wire logic                  srst,
   input wire logic                  ce,
   input wire logic [GPC_ADDR_W-1:0] addr,
   input wire logic [GPC_DATA_W-1:0] wr_data,
   input wire logic                  wr_stb,
   input wire logic                  rd_stb,
   input wire logic [GPC_DATA_W-1:0] rd_data,
   input wire logic [NPIN-1:0]       gpio_i,
   input wire logic [NPIN-1:0]       gpio_o,
   input wire logic [NPIN-1:0]       gpio_oe,
   input wire logic [NPIN-1:0]       test_sig,
   input wire logic [NPIN-1:0]       mode_strap,
   input wire logic                  mode_strap_valid
);
   // ====
   // Pin outputs, two edges after a control write.
   wire wr_c = ce && wr_stb && addr == GPC_OFS_PIN_CTRL;
   default clocking @(posedge mclk); endclocking
   default disable iff (srst);
   property p_oe0; wr_c ##1 ce |=> gpio_oe[0] == $past(wr_data[1], 2); endproperty
   a_oe0: assert property (p_oe0) else $error("pin 0 enable wrong");
   property p_oe1; wr_c ##1 ce |=> gpio_oe[1] == $past(wr_data[5], 2); endproperty
   a_oe1: assert property (p_oe1) else $error("pin 1 enable wrong");
   property p_dat0; wr_c && !wr_data[2] ##1 ce |=> gpio_o[0] == $past(wr_data[3], 2); endproperty
   a_dat0: assert property (p_dat0) else $error("pin 0 data wrong");
   property p_dat1; wr_c && !wr_data[6] ##1 ce |=> gpio_o[1] == $past(wr_data[7], 2); endproperty
   a_dat1: assert property (p_dat1) else $error("pin 1 data wrong");
   property p_tst0; wr_c && wr_data[2] ##1 ce |=> gpio_o[0] == $past(test_sig[0]); endproperty
   a_tst0: assert property (p_tst0) else $error("pin 0 test source wrong");
   property p_tst1; wr_c && wr_data[6] ##1 ce |=> gpio_o[1] == $past(test_sig[1]); endproperty
   a_tst1: assert property (p_tst1) else $error("pin 1 test source wrong");
   // ====
   // Straps are taken once, at the first enabled edge after reset.
   property p_cap; $past(srst) && ce |=> mode_strap_valid && mode_strap == $past(gpio_i); endproperty
   a_cap: assert property (p_cap) else $error("strap capture wrong");
   property p_hold; mode_strap_valid |=> $stable(mode_strap); endproperty
   a_hold: assert property (p_hold) else $error("strap changed");
endmodule
`default_nettype wire

/* test/gpc_board.sv */
// Board side of the two pins: strap resistors on each wire.
// Assumes gpio_o and gpio_oe come straight from the block.
`timescale 1ns/1ps
`default_nettype none
module gpc_board (
   input  wire logic [1:0] gpio_o,
   input  wire logic [1:0] gpio_oe,
   input  wire logic [1:0] strap_lvl,
   output var  logic [1:0] gpio_i
);
   // A released pin falls to its resistor, not to the last driven level.
   assign gpio_i = (gpio_oe & gpio_o) | (~gpio_oe & strap_lvl);
endmodule
`default_nettype wire

/* test/gpc_pin_pair_tb.sv */
// Self-checking bench for the two-pin I/O control block.
// Assumes package, design, board model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module gpc_pin_pair_tb
   import gpc_pkg::*;
;
   logic        mclk, srst, ce, wr_stb, rd_stb, mode_strap_valid;
   logic [11:0] addr;
   logic [31:0] wr_data, rd_data, q, w;
   logic [1:0]  gpio_i, gpio_o, gpio_oe, test_sig, mode_strap, ext, s, eo;
   int          seed, mismatches, n_tests;
   gpc_pin_pair dut_u (.mclk(mclk), .srst(srst), .ce(ce), .addr(addr), .wr_data(wr_data),
      .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .gpio_i(gpio_i), .gpio_o(gpio_o),
      .gpio_oe(gpio_oe), .test_sig(test_sig), .mode_strap(mode_strap), .mode_strap_valid(mode_strap_valid));
   gpc_board brd_u (.gpio_o(gpio_o), .gpio_oe(gpio_oe), .strap_lvl(ext), .gpio_i(gpio_i));
   // ====
   // Bus tasks and expectations.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] v);
      addr <= a;
      wr_data <= v;
      wr_stb <= 1'b1;
      @(posedge mclk);
      wr_stb <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] v);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge mclk);
      rd_stb <= 1'b0;
      @(posedge mclk);
      v = rd_data;
   endtask
   function automatic logic [31:0] exp_rd(input logic [7:0] c, input logic [1:0] ts, input logic [1:0] e);
      logic [7:0] r;
      r = c;
      for (int p = 0; p < 2; p++) begin
         if (c[4*p]) r[4*p+3] = c[4*p+1] ? (c[4*p+2] ? ts[p] : c[4*p+3]) : e[p];
      end
      return {24'h00_0000, r};
   endfunction
   task automatic conclude;
      if (mismatches == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // ====
   // Main sequence.
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   initial begin
      seed = 59789;
      mismatches = 0;
      n_tests = 0;
      srst = 1'b1;
      ce = 1'b1;
      wr_stb = 1'b0;
      rd_stb = 1'b0;
      addr = 12'h000;
      wr_data = 32'h0000_0000;
      test_sig = 2'b00;
      ext = 2'($random(seed));
      s = ext;
      repeat (16) @(posedge mclk);
      srst <= 1'b0;
      @(posedge mclk);
      rd(GPC_OFS_PIN_CTRL, q);
      chk(q, exp_rd(GPC_CTRL_RST, 2'b00, ext));
      // The read answer stands for one cycle only, then the port falls back to zero.
      @(posedge mclk);
      chk(rd_data, 32'h0000_0000);
      rd(12'h0FC, q);
      chk(q, 32'h0000_0000);
      for (int i = 0; i < 40; i++) begin
         w = $random(seed);
         test_sig <= 2'($random(seed));
         ext <= 2'($random(seed));
         wr(GPC_OFS_PIN_CTRL, w);
         repeat (2) @(posedge mclk);
         eo = {w[6] ? test_sig[1] : w[7], w[2] ? test_sig[0] : w[3]};
         chk({30'h0000_0000, gpio_oe}, {30'h0000_0000, w[5], w[1]});
         chk({30'h0000_0000, gpio_o}, {30'h0000_0000, eo});
         if (i[0]) begin
            ce <= 1'b0;
            wr(GPC_OFS_PIN_CTRL, ~w);
            ce <= 1'b1;
         end else wr(12'h010, ~w);
         rd(GPC_OFS_PIN_CTRL, q);
         chk(q, exp_rd(w[7:0], test_sig, ext));
      end
      rd(GPC_OFS_STRAP, q);
      chk(q, {29'h0000_0000, 1'b1, s});
      chk({29'h0000_0000, mode_strap_valid, mode_strap}, {29'h0000_0000, 1'b1, s});
      // A second reset in mid-run must release both pins and take fresh straps.
      s = 2'($random(seed));
      ext <= s;
      srst <= 1'b1;
      repeat (2) @(posedge mclk);
      chk({30'h0000_0000, gpio_oe}, 32'h0000_0000);
      srst <= 1'b0;
      @(posedge mclk);
      rd(GPC_OFS_STRAP, q);
      chk(q, {29'h0000_0000, 1'b1, s});
      conclude();
   end
endmodule
bind gpc_pin_pair gpc_pin_pair_props #(.NPIN(NPIN)) prop_u (.mclk(mclk), .srst(srst), .ce(ce), .addr(addr),
   .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .gpio_i(gpio_i), .gpio_o(gpio_o),
   .gpio_oe(gpio_oe), .test_sig(test_sig), .mode_strap(mode_strap), .mode_strap_valid(mode_strap_valid));
`default_nettype wire
